// file: shared/ebpi_pkg.sv
// Constants and types for the external bus pin interface.
// Assumes a single 50 MHz clock domain and an active-low async reset.
//
// Notes on behaviour
// R1: Reset input low puts and holds the device in reset.
// R2: Reset output pin carries the internal watchdog reset to outside devices.
// R3: Standby input low forces hardware standby whatever the device is doing.
// R4: External master holds bus request asserted while it needs the bus.
// R5: After releasing the bus, device asserts grant acknowledge to the master.
// R6: Nonmaskable interrupt input edge raises a request that masking cannot stop.
// R7: Six maskable interrupt inputs, five down to zero, each request interrupts.
// R8: External addresses go out on a 24-bit address bus, 23 down to 0.
// R9: Data bus is 16-bit bidirectional; device drives writes, outside drives reads.
// R10: Eight active-low area selects, seven to zero, assert for accessed area.
// R11: Address strobe goes low only while a valid address is output.
// R12: Read strobe stays low during an external read.
// R13: Upper write strobe low while valid write data sits on bits 15 to 8.
// R14: Lower write strobe low while valid write data sits on bits 7 to 0.
// R15: Wait input during an access stretches the cycle with wait states.
// R16: Mode pins 001..100 give modes 1..4; other patterns are invalid.
package ebpi_pkg;
   localparam int EBPI_ADDR_W = 24;
   localparam int EBPI_DATA_W = 16;
   localparam int EBPI_AREAS = 8;
   localparam int EBPI_IRQS = 6;
   localparam int EBPI_AREA_LSB = 21;
   localparam logic [2:0] EBPI_MD_MODE1 = 3'h1;
   localparam logic [2:0] EBPI_MD_MODE2 = 3'h2;
   localparam logic [2:0] EBPI_MD_MODE3 = 3'h3;
   localparam logic [2:0] EBPI_MD_MODE4 = 3'h4;
   typedef enum logic [2:0] {
      EBPI_MODE_BAD, EBPI_MODE_1, EBPI_MODE_2, EBPI_MODE_3, EBPI_MODE_4
   } ebpi_mode_t;
   typedef enum logic [2:0] {
      EBPI_IDLE, EBPI_ADDR, EBPI_STROBE, EBPI_END, EBPI_RELEASED
   } ebpi_state_t;
endpackage

// file: shared/ebpi_sync_if.sv
// Bundle of synchronised pin levels from the input stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ebpi_sync_if;
   logic reset_n;
   logic standby_n;
   logic ext_bus_request_n_n;
   logic wait_n;
   logic nmi;
   logic [5:0] irq_n;
   logic [15:0] data;
   modport producer (output reset_n, standby_n, ext_bus_request_n_n, wait_n, nmi,
      irq_n, data);
   modport consumer (input reset_n, standby_n, ext_bus_request_n_n, wait_n, nmi,
      irq_n, data);
endinterface

// file: verilog/ebpi_pin_sync.sv
// Two-flop synchronisers for every asynchronous pin input except the mode pins.
// Assumes the pins are unrelated to clk_in.
`timescale 1ns/1ps
module ebpi_pin_sync
   import ebpi_pkg::*;
#(
   parameter int WIDTH = 27
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] pins_in,
   ebpi_sync_if.producer sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= {WIDTH{1'b1}};
         sync_q <= {WIDTH{1'b1}};
      end else begin
         meta_q <= pins_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out.reset_n = sync_q[0];
   assign sync_out.standby_n = sync_q[1];
   assign sync_out.ext_bus_request_n_n = sync_q[2];
   assign sync_out.wait_n = sync_q[3];
   assign sync_out.nmi = sync_q[4];
   assign sync_out.irq_n = sync_q[10:5];
   assign sync_out.data = sync_q[26:11];
endmodule

// file: verilog/ebpi_top.sv
// External bus and system-control pin logic of the device.
// Assumes an internal master issuing one access at a time on req_in.
`timescale 1ns/1ps
module ebpi_top
   import ebpi_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic chip_reset_in_n_in,
   input wire logic wdt_reset_in,
   output logic watchdog_reset_out_n_out,
   input wire logic hw_standby_in_n_in,
   output logic hw_standby_out,
   output logic chip_in_reset_out,
   input wire logic ext_bus_request_n_in,
   output logic bus_grant_ack_n_out,
   input wire logic nmi_pin_in,
   input wire logic [5:0] irq_pins_n_in,
   output logic nmi_req_out,
   input wire logic nmi_clear_in,
   output logic [5:0] irq_req_out,
   input wire logic [2:0] op_mode_pins_in,
   output ebpi_mode_t op_mode_out,
   output logic op_mode_invalid_out,
   input wire logic req_in,
   input wire logic req_write_in,
   input wire logic [1:0] req_byte_en_in,
   input wire logic [23:0] req_addr_in,
   input wire logic [15:0] req_wdata_in,
   output logic req_ready_out,
   output logic req_done_out,
   output logic [15:0] req_rdata_out,
   output logic [23:0] addr_out,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe_out,
   output logic [7:0] area_sel_n_out,
   output logic addr_strobe_n_out,
   output logic read_strobe_n_out,
   output logic upper_byte_write_n_out,
   output logic lower_byte_write_n_out,
   input wire logic wait_n_in
);
   ebpi_sync_if sync ();
   ebpi_pin_sync #(.WIDTH(27)) u_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pins_in({data_in, irq_pins_n_in, nmi_pin_in, wait_n_in,
         ext_bus_request_n_in, hw_standby_in_n_in, chip_reset_in_n_in}),
      .sync_out(sync)
   );

   ebpi_state_t state_q;
   logic in_reset;
   logic standby;
   logic is_write_q;
   logic [1:0] be_q;
   logic nmi_prev_q;
   logic [2:0] mode_pins_q;
   logic [2:0] mode_meta_q;
   logic [2:0] mode_sync_q;
   logic [1:0] settle_q;
   logic strobe_end;

   assign in_reset = !sync.reset_n; // R1
   assign standby = !sync.standby_n; // R3
   assign chip_in_reset_out = in_reset;
   assign hw_standby_out = standby;
   assign req_ready_out = (state_q == EBPI_IDLE) && sync.ext_bus_request_n_n
      && !in_reset && !standby;
   // Strobe phase ends once data and wait have crossed both sync stages
   assign strobe_end = (state_q == EBPI_STROBE) && settle_q[1]
      && sync.wait_n; // R15

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         watchdog_reset_out_n_out <= 1'b1;
      end else begin
         watchdog_reset_out_n_out <= !wdt_reset_in; // R2
      end
   end

   // Hold strobes until both pin sync stages have seen them
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         settle_q <= 2'h0;
      end else if (state_q == EBPI_STROBE) begin
         settle_q <= {settle_q[0], 1'b1};
      end else begin
         settle_q <= 2'h0;
      end
   end

   // Bus cycle sequencer
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= EBPI_IDLE;
      end else if (in_reset || standby) begin // R1 R3
         state_q <= EBPI_IDLE;
      end else begin
         case (state_q)
            EBPI_IDLE: begin
               if (!sync.ext_bus_request_n_n) begin // R4
                  state_q <= EBPI_RELEASED;
               end else if (req_in) begin
                  state_q <= EBPI_ADDR;
               end
            end
            EBPI_ADDR: state_q <= EBPI_STROBE;
            EBPI_STROBE: begin
               if (strobe_end) begin // R15
                  state_q <= EBPI_END;
               end
            end
            EBPI_END: state_q <= EBPI_IDLE;
            EBPI_RELEASED: begin
               if (sync.ext_bus_request_n_n) begin // R4
                  state_q <= EBPI_IDLE;
               end
            end
            default: state_q <= EBPI_IDLE;
         endcase
      end
   end

   // Pin outputs of an access
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         addr_out <= 24'h000000;
         data_out <= 16'h0000;
         is_write_q <= 1'b0;
         be_q <= 2'h0;
         area_sel_n_out <= 8'hff;
         addr_strobe_n_out <= 1'b1;
         read_strobe_n_out <= 1'b1;
         upper_byte_write_n_out <= 1'b1;
         lower_byte_write_n_out <= 1'b1;
         data_oe_out <= 1'b0;
         bus_grant_ack_n_out <= 1'b1;
      end else if (in_reset || standby) begin
         area_sel_n_out <= 8'hff;
         addr_strobe_n_out <= 1'b1;
         read_strobe_n_out <= 1'b1;
         upper_byte_write_n_out <= 1'b1;
         lower_byte_write_n_out <= 1'b1;
         data_oe_out <= 1'b0;
         bus_grant_ack_n_out <= 1'b1;
      end else begin
         // Grant only once every strobe has been released
         bus_grant_ack_n_out <= !(state_q == EBPI_RELEASED
            && sync.ext_bus_request_n_n == 1'b0); // R5
         if (state_q == EBPI_IDLE && req_ready_out && req_in) begin
            addr_out <= req_addr_in; // R8
            data_out <= req_wdata_in;
            is_write_q <= req_write_in;
            be_q <= req_byte_en_in;
            area_sel_n_out <= ~(8'h01 << req_addr_in[23:EBPI_AREA_LSB]); // R10
            addr_strobe_n_out <= 1'b0; // R11
            data_oe_out <= req_write_in; // R9
         end else if (state_q == EBPI_ADDR) begin
            read_strobe_n_out <= is_write_q; // R12
            upper_byte_write_n_out <= !(is_write_q && be_q[1]); // R13
            lower_byte_write_n_out <= !(is_write_q && be_q[0]); // R14
         end else if (strobe_end) begin // R15
            addr_strobe_n_out <= 1'b1;
            read_strobe_n_out <= 1'b1;
            upper_byte_write_n_out <= 1'b1;
            lower_byte_write_n_out <= 1'b1;
         end else if (state_q == EBPI_END) begin
            area_sel_n_out <= 8'hff;
            data_oe_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_done_out <= 1'b0;
         req_rdata_out <= 16'h0000;
      end else begin
         req_done_out <= strobe_end && !in_reset && !standby;
         if (strobe_end && !is_write_q) begin
            req_rdata_out <= sync.data; // R9
         end
      end
   end

   // Interrupt inputs
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nmi_prev_q <= 1'b1;
         nmi_req_out <= 1'b0;
         irq_req_out <= 6'h00;
      end else begin
         nmi_prev_q <= sync.nmi;
         if (nmi_prev_q && !sync.nmi) begin // R6
            nmi_req_out <= 1'b1;
         end else if (nmi_clear_in) begin
            nmi_req_out <= 1'b0;
         end
         irq_req_out <= ~sync.irq_n; // R7
      end
   end

   // Mode pins pass two flops like every other pin
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_meta_q <= 3'h0;
         mode_sync_q <= 3'h0;
      end else begin
         mode_meta_q <= op_mode_pins_in;
         mode_sync_q <= mode_meta_q;
      end
   end

   // Mode pins latched while reset is held
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_pins_q <= 3'h0;
      end else if (in_reset) begin
         mode_pins_q <= mode_sync_q;
      end
   end

   always_comb begin
      case (mode_pins_q) // R16
         EBPI_MD_MODE1: op_mode_out = EBPI_MODE_1;
         EBPI_MD_MODE2: op_mode_out = EBPI_MODE_2;
         EBPI_MD_MODE3: op_mode_out = EBPI_MODE_3;
         EBPI_MD_MODE4: op_mode_out = EBPI_MODE_4;
         default: op_mode_out = EBPI_MODE_BAD;
      endcase
      op_mode_invalid_out = (op_mode_out == EBPI_MODE_BAD);
   end
endmodule

// file: verif/ebpi_ext_mem.sv
// Behavioural external memory on the bus pins, with a wait knob.
// Assumes the pin names of ebpi_top and a single clock.
`timescale 1ns/1ps
module ebpi_ext_mem (
   input wire logic clk_in,
   input wire logic [23:0] addr_out,
   input wire logic [15:0] data_out,
   input wire logic read_strobe_n_out,
   input wire logic upper_byte_write_n_out,
   input wire logic lower_byte_write_n_out,
   input wire logic [3:0] wait_cyc,
   output logic [15:0] data_in,
   output logic wait_n_in
);
   logic [15:0] mem [16];
   logic [15:0] last_q = 16'h0;
   logic [3:0] cnt_q = 4'h0;
   logic idle;
   logic [3:0] ix;
   assign ix = addr_out[4:1];
   assign idle = read_strobe_n_out && upper_byte_write_n_out
      && lower_byte_write_n_out;
   // Drives only while read strobe low, else stale inverse
   assign data_in = !read_strobe_n_out ? mem[ix] : ~last_q;
   assign wait_n_in = (cnt_q == 4'h0);
   always @(posedge clk_in) begin
      cnt_q <= idle ? wait_cyc : cnt_q - 4'(cnt_q != 4'h0);
      if (!read_strobe_n_out) last_q <= data_in;
      if (!upper_byte_write_n_out) mem[ix][15:8] <= data_out[15:8];
      if (!lower_byte_write_n_out) mem[ix][7:0] <= data_out[7:0];
   end
endmodule

// file: verif/ebpi_top_asserts.sv
// Pin-level checks of the external bus block.
// Assumes it is bound to ebpi_top and sees only its ports.
`timescale 1ns/1ps
module ebpi_top_asserts
   import ebpi_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic wdt_reset_in,
   input wire logic watchdog_reset_out_n_out,
   input wire logic hw_standby_in_n_in,
   input wire logic hw_standby_out,
   input wire logic chip_reset_in_n_in,
   input wire logic chip_in_reset_out,
   input wire logic nmi_pin_in,
   input wire logic nmi_req_out,
   input wire logic [5:0] irq_pins_n_in,
   input wire logic [5:0] irq_req_out,
   input wire logic bus_grant_ack_n_out,
   input wire logic [23:0] addr_out,
   input wire logic data_oe_out,
   input wire logic [7:0] area_sel_n_out,
   input wire logic addr_strobe_n_out,
   input wire logic read_strobe_n_out,
   input wire logic upper_byte_write_n_out,
   input wire logic lower_byte_write_n_out,
   input wire logic wait_n_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence held_wait; !wait_n_in [*3]; endsequence
   sequence rd_phase; !read_strobe_n_out throughout held_wait; endsequence
   area_select_a: assert property (!addr_strobe_n_out |->
      area_sel_n_out == ~(8'h1 << addr_out[23:21])) else $error("area sel");
   read_dir_a: assert property (!read_strobe_n_out |-> !data_oe_out)
      else $error("read drives bus");
   upper_wr_a: assert property (!upper_byte_write_n_out |-> data_oe_out)
      else $error("upper write idle bus");
   lower_wr_a: assert property (!lower_byte_write_n_out |-> data_oe_out)
      else $error("lower write idle bus");
   wdt_out_a: assert property (watchdog_reset_out_n_out ==
      !$past(wdt_reset_in)) else $error("reset out");
   standby_pin_a: assert property (!hw_standby_in_n_in [*3] |->
      hw_standby_out ##1 addr_strobe_n_out) else $error("standby");
   chip_reset_a: assert property (!chip_reset_in_n_in [*3] |->
      chip_in_reset_out ##1 addr_strobe_n_out) else $error("chip reset");
   grant_bus_a: assert property (!bus_grant_ack_n_out |->
      addr_strobe_n_out && read_strobe_n_out && !data_oe_out)
      else $error("granted bus driven");
   nmi_edge_a: assert property ($fell(nmi_pin_in) |->
      ##[1:4] nmi_req_out) else $error("nmi lost");
   irq_level_a: assert property ($stable(irq_pins_n_in) [*4] |->
      irq_req_out == ~irq_pins_n_in) else $error("irq level");
   wait_hold_a: assert property (rd_phase |=> !read_strobe_n_out)
      else $error("wait ignored");
endmodule

// file: verif/ebpi_top_test.sv
// Self-checking bench of ebpi_top with an external memory model.
// Assumes ebpi_pkg, ebpi_top, ebpi_ext_mem and the checker compiled.
`timescale 1ns/1ps
module ebpi_top_test;
   import ebpi_pkg::*;
   logic clk_in = 0, rst_b_in = 0, chip_reset_in_n_in = 1;
   logic wdt_reset_in = 0, hw_standby_in_n_in = 1, nmi_pin_in = 1;
   logic ext_bus_request_n_in = 1, nmi_clear_in = 0, req_in = 0;
   logic req_write_in = 0, watchdog_reset_out_n_out, hw_standby_out;
   logic [5:0] irq_pins_n_in = 6'h3f, irq_req_out;
   logic [2:0] op_mode_pins_in = 3'h1;
   logic [1:0] req_byte_en_in = 2'h3;
   logic [23:0] req_addr_in = 24'h0, addr_out;
   logic [15:0] req_wdata_in = 16'h0, data_in, req_rdata_out, data_out;
   logic [3:0] wait_cyc = 4'h0;
   logic chip_in_reset_out, bus_grant_ack_n_out, nmi_req_out, wait_n_in;
   logic op_mode_invalid_out, req_ready_out, req_done_out, data_oe_out;
   logic addr_strobe_n_out, read_strobe_n_out;
   logic upper_byte_write_n_out, lower_byte_write_n_out;
   logic [7:0] area_sel_n_out;
   ebpi_mode_t op_mode_out;
   int failures = 0, num_checks = 0, lat;
   ebpi_top dut_u (.*);
   ebpi_ext_mem mem_u (.*);
   always #10 clk_in = ~clk_in;
   task automatic chk(input string nm, input logic [23:0] e, g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic acc(input logic w, input logic [1:0] be,
      input logic [23:0] a, input logic [15:0] d);
      int n = 0;
      @(posedge clk_in);
      req_in <= 1;
      req_write_in <= w;
      req_byte_en_in <= be;
      req_addr_in <= a;
      req_wdata_in <= d;
      do @(negedge clk_in); while (req_ready_out !== 1 && ++n < 50);
      chk("ready", 1, req_ready_out);
      @(posedge clk_in);
      req_in <= 0;
      lat = 0;
      do @(negedge clk_in); while (req_done_out !== 1 && ++lat < 40);
      chk("done", 1, req_done_out);
   endtask
   task automatic t_mode;
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_in);
         chip_reset_in_n_in <= 0;
         op_mode_pins_in <= (i == 8) ? 3'h3 : 3'(i);
         cyc(4);
         @(negedge clk_in);
         chk("in_reset", 1, chip_in_reset_out);
         chk("mode_bad", i == 0 || (i > 4 && i < 8), op_mode_invalid_out);
         chk("mode", (i % 8 > 4) ? 0 : (i == 8 ? 3 : i), op_mode_out);
      end
      @(posedge clk_in);
      chip_reset_in_n_in <= 1;
      cyc(4);
      $display("t_mode done");
   endtask
   task automatic t_rw;
      for (int k = 0; k < 8; k++) begin
         acc(1, 2'h3, {3'(k), 21'h6}, {8'ha5, 5'h0, 3'(k)});
         chk("wr_lat", 4, lat);
         acc(1, 2'h2, {3'(k), 21'h6}, 16'h3cff);
         acc(0, 2'h3, {3'(k), 21'h6}, 16'h0);
         chk("rd_lat", 4, lat);
         chk("rdata", {8'h3c, 5'h0, 3'(k)}, req_rdata_out);
      end
      $display("t_rw done");
   endtask
   task automatic t_wait;
      @(posedge clk_in);
      wait_cyc <= 4'h3;
      acc(0, 2'h3, 24'he00006, 16'h0);
      chk("wait_lat", 1, lat >= 6 && lat <= 12);
      chk("wait_rdata", 16'h3c07, req_rdata_out);
      @(posedge clk_in);
      wait_cyc <= 4'h0;
      $display("t_wait done");
   endtask
   task automatic t_pins;
      int n = 0;
      @(posedge clk_in);
      ext_bus_request_n_in <= 0;
      irq_pins_n_in <= 6'h2a;
      nmi_pin_in <= 0;
      wdt_reset_in <= 1;
      do @(negedge clk_in); while (bus_grant_ack_n_out !== 0 && ++n < 9);
      chk("grant", 0, bus_grant_ack_n_out);
      chk("ready", 0, req_ready_out);
      chk("reset_out", 0, watchdog_reset_out_n_out);
      cyc(3);
      @(negedge clk_in);
      chk("irq", 6'h15, irq_req_out);
      chk("nmi", 1, nmi_req_out);
      @(posedge clk_in);
      ext_bus_request_n_in <= 1;
      nmi_clear_in <= 1;
      wdt_reset_in <= 0;
      hw_standby_in_n_in <= 0;
      @(posedge clk_in);
      nmi_clear_in <= 0;
      cyc(4);
      @(negedge clk_in);
      chk("grant_off", 1, bus_grant_ack_n_out);
      chk("nmi_level", 0, nmi_req_out);
      chk("standby", 1, hw_standby_out);
      chk("sb_ready", 0, req_ready_out);
      @(posedge clk_in);
      hw_standby_in_n_in <= 1;
      nmi_pin_in <= 1;
      cyc(5);
      $display("t_pins done");
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      cyc(10);
      rst_b_in <= 1;
      cyc(3);
      t_mode;
      t_rw;
      t_wait;
      t_pins;
      print_verdict;
   end
   initial begin
      #100000;
      failures++;
      print_verdict;
   end
endmodule
bind ebpi_top ebpi_top_asserts chk_u (.*);
